// *** mioe_pkg.sv ***
// Purpose: shared constants and types for the io, enable, serial and interrupt block
// Assumes: one instruction cycle per CLOCK edge with CE high
// Notes: opcodes are decoded outside; this block takes a micro-op code
package mioe_pkg;
    localparam int MIOE_PTR_W = 6;
    localparam int MIOE_DIG_W = 4;
    localparam int MIOE_PC_W = 10;
    localparam int MIOE_MEM_DEPTH = 64;
    localparam logic [9:0] MIOE_INT_VECTOR = 10'h0FF;
    localparam logic [3:0] MIOE_EN_RESET = 4'h0;
    localparam int MIOE_EN_COUNT = 0;
    localparam int MIOE_EN_ARM = 1;
    localparam int MIOE_EN_DRIVE = 2;
    localparam int MIOE_EN_SOUT = 3;
    localparam int MIOE_MIN_PULSE_CYC = 2;

    typedef enum logic [3:0] {
        MIOE_OP_NONE = 4'h0,
        MIOE_OP_ALU = 4'h1,
        MIOE_OP_LOAD_PTR = 4'h2,
        MIOE_OP_LOAD_DIRECT = 4'h3,
        MIOE_OP_EXCH_DIRECT = 4'h4,
        MIOE_OP_PTR_TO_DIGIT = 4'h5,
        MIOE_OP_LOAD_ENABLE = 4'h6,
        MIOE_OP_SWAP_SERIAL = 4'h7,
        MIOE_OP_BYTE_FROM_MEM = 4'h8,
        MIOE_OP_BYTE_FROM_ROM = 4'h9,
        MIOE_OP_PORT_TO_ACC = 4'hA,
        MIOE_OP_PORT_TO_MEM = 4'hB,
        MIOE_OP_LOAD_GENERAL = 4'hC,
        MIOE_OP_RETURN = 4'hD,
        MIOE_OP_CALL = 4'hE
    } mioe_op_type;

    typedef enum logic [1:0] {
        MIOE_ALU_ADD = 2'h0,
        MIOE_ALU_ADDC = 2'h1,
        MIOE_ALU_XOR = 2'h2,
        MIOE_ALU_LOAD = 2'h3
    } mioe_alu_type;
endpackage

// *** mioe_mem_if.sv ***
// Purpose: carrier between the core and its digit memory
// Assumes: single clock, one access per cycle
// Notes: read data registered inside the memory
`timescale 1ns/10ps
`default_nettype none
interface mioe_mem_if;
    logic [5:0] addr;
    logic we;
    logic [3:0] wdata;
    logic [3:0] rdata;
    modport core (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** mioe_digit_mem.sv ***
// Purpose: 64 x 4 digit memory, bank in upper address bits
// Assumes: write-first not required; read data registered
// Notes: contents are not cleared by reset, software clears them
`timescale 1ns/10ps
`default_nettype none
module mioe_digit_mem (
    input wire logic CLOCK, // instruction clock
    input wire logic CE, // clock enable
    mioe_mem_if.mem port // memory access
);
    import mioe_pkg::*;
    logic [3:0] cells [MIOE_MEM_DEPTH];
    logic [3:0] rdata_r;
    always_ff @(posedge CLOCK) begin
        if (CE) begin
            if (port.we) begin
                cells[port.addr] <= port.wdata;
            end
            rdata_r <= cells[port.addr];
        end
    end
    assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// *** mioe_core.sv ***
// What this block does
// R01: memory is four banks of sixteen digits, pointer top bits bank, low bits digit
// R02: direct load and exchange address memory from operand, not pointer
// R03: general outputs come from digit register loaded from pointer digit part
// R04: four-bit adder writes accumulator, carry out goes to carry flag
// R05: host bus option turns inputs one to three into read, select, write
// R06: host bus option makes general port bit zero an output
// R07: byte latch loads from memory, accumulator or program, drives port when enabled
// R08: host write strobe captures eight port lines into byte latch
// R09: port lines readable into accumulator and addressed memory digit
// R10: feature-enable register written by load-enable, arm bit also cleared by interrupt, each bit one feature
// R11: serial exchange swaps serial register and accumulator
// R12: counter mode decrements on falling serial input, pulses two cycles minimum
// R13: counter mode: clock out holds carry from exchange, serial out equals bit three
// R14: shift mode shifts left each cycle, serial input enters low bit
// R15: shift mode sync pulses start at exchange with carry 1, stop with 0
// R16: shift mode serial out is top bit if bit three set, else 0
// R17: arm bit enables input one interrupt, cleared when interrupt taken
// R18: drive bit enables port drivers; ignored with host bus option
// R19: interrupt pushes next address on three-level stack, jumps to 0FF
// R20: interrupt taken when armed, pulse seen, instruction done, no chain active
// R21: skip state saved at interrupt, restored by next return
// R22: program places no-op at 0FF and re-arms before return
// R23: everything on instruction clock, except counter decrement from serial input; here edges are counted on SERIAL_CLK, register decremented on CLOCK
//
// Purpose: data path, port, feature enable, serial and interrupt of a 4-bit controller
// Assumes: op, operand and rom byte arrive decoded with ins_done on the last cycle
// Notes: counter input is on the link clock domain; the falling-edge count crosses as a registered gray code
`timescale 1ns/10ps
`default_nettype none
module mioe_core (
    input wire logic CLOCK, // instruction cycle clock
    input wire logic RST, // sync reset, active high
    input wire logic CE, // clock enable
    input wire logic SERIAL_CLK, // link clock sampling the serial input
    input wire logic SERIAL_IN, // serial or counter input
    input wire mioe_pkg::mioe_op_type OP, // decoded operation
    input wire mioe_pkg::mioe_alu_type ALU_FN, // adder function
    input wire logic [7:0] OPERAND, // operand or rom byte
    input wire logic [9:0] PC_NEXT, // next sequential address
    input wire logic INS_DONE, // current instruction completes
    input wire logic CHAIN_BUSY, // jump or pointer-load chain in progress
    input wire logic SKIP_IN, // pending skip state
    input wire logic HOST_OPTION, // fixed host bus option strap
    input wire logic [3:0] GEN_INPUTS, // general inputs, pins
    input wire logic [7:0] PORT_I, // port pin levels
    output logic [7:0] PORT_O, // port drive data
    output logic [7:0] PORT_OE, // port drive enable
    input wire logic [3:0] GPORT_I, // general port pin levels
    output logic [3:0] GPORT_O, // general port drive data
    output logic [3:0] GPORT_OE, // general port drive enable
    output logic [3:0] DIGIT_OUT, // general outputs
    output logic SERIAL_OUT, // serial output
    output logic SYNC_CLOCK_OUT, // sync or carry clock output
    output logic [3:0] ACC, // accumulator
    output logic CARRY, // carry flag
    output logic [3:0] FEATURE_ENABLE, // feature-enable register
    output logic INT_TAKE, // pulse: interrupt taken this cycle
    output logic [9:0] PC_LOAD, // jump target on interrupt or return
    output logic SKIP_OUT, // restored skip on return
    output logic [29:0] RETURN_STACK // three levels, level1 in low bits
);
    import mioe_pkg::*;

    typedef struct packed {
        logic [5:0] ptr;
        logic [3:0] acc;
        logic carry;
        logic [3:0] digit;
        logic [3:0] gen;
        logic [7:0] byte_latch;
        logic [3:0] feature_enable;
        logic [3:0] serial_count_reg;
        logic carry_hold;
        logic sync_on;
        logic [9:0] return_level1;
        logic [9:0] return_level2;
        logic [9:0] return_level3;
        logic saved_skip;
        logic [2:0] in1_s;
        logic [2:0] si_tog_s;
        logic [2:0] wr_s;
        logic [1:0] in1_low_cnt;
        logic int_pending;
        logic [3:0] dec_seen;
        logic [7:0] port_rd;
    } mioe_state_type;

    mioe_state_type st_r;
    mioe_state_type st_nxt;
    mioe_mem_if mem_bus ();

    // link domain: count falling edges of the serial input in a binary counter
    logic [2:0] si_sync_r;
    logic [3:0] dec_cnt_r;
    always_ff @(posedge SERIAL_CLK) begin
        if (RST) begin
            si_sync_r <= 3'h7;
            dec_cnt_r <= 4'h0;
        end else begin
            si_sync_r <= {si_sync_r[1:0], SERIAL_IN};
            if (si_sync_r[2] & ~si_sync_r[1]) begin
                dec_cnt_r <= dec_cnt_r + 4'h1; // R12
            end
        end
    end
    // gray count registered at the source so the crossing never sees a glitch
    logic [3:0] dec_gray_r;
    always_ff @(posedge SERIAL_CLK) begin
        if (RST) begin
            dec_gray_r <= 4'h0;
        end else begin
            dec_gray_r <= dec_cnt_r ^ (dec_cnt_r >> 1);
        end
    end
    logic [3:0] dg_s1_r;
    logic [3:0] dg_s2_r;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dg_s1_r <= 4'h0;
            dg_s2_r <= 4'h0;
        end else if (CE) begin
            dg_s1_r <= dec_gray_r;
            dg_s2_r <= dg_s1_r;
        end
    end

    function automatic logic [3:0] gray2bin(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        b[2] = b[3] ^ g[2];
        b[1] = b[2] ^ g[1];
        b[0] = b[1] ^ g[0];
        return b;
    endfunction

    function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
                                        input logic ci);
        return {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    logic [3:0] dec_bin;
    logic [3:0] dec_delta;
    logic [4:0] sum;
    logic mem_direct;
    logic host_wr;
    logic int_take;
    logic [3:0] mem_rd;
    assign dec_bin = gray2bin(dg_s2_r);
    assign dec_delta = dec_bin - st_r.dec_seen;
    assign mem_rd = mem_bus.rdata;
    // host bus strobes active low: inputs one read, two select, three write
    assign host_wr = HOST_OPTION & ~st_r.wr_s[2] & st_r.wr_s[1] & ~GEN_INPUTS[2]; // R05 R08
    assign mem_direct = (OP == MIOE_OP_LOAD_DIRECT) || (OP == MIOE_OP_EXCH_DIRECT);
    assign int_take = st_r.int_pending & st_r.feature_enable[MIOE_EN_ARM] & INS_DONE
                      & ~CHAIN_BUSY; // R20

    always_comb begin
        st_nxt = st_r;
        sum = 5'h00;
        st_nxt.in1_s = {st_r.in1_s[1:0], GEN_INPUTS[1]};
        st_nxt.wr_s = {st_r.wr_s[1:0], GEN_INPUTS[3]};
        st_nxt.port_rd = PORT_I;
        // low width measured on agreeing stages two and three
        if (!st_r.in1_s[2] && !st_r.in1_s[1]) begin
            if (st_r.in1_low_cnt != 2'(MIOE_MIN_PULSE_CYC)) begin
                st_nxt.in1_low_cnt = st_r.in1_low_cnt + 2'h1;
            end
        end else begin
            st_nxt.in1_low_cnt = 2'h0;
        end
        if (st_r.feature_enable[MIOE_EN_ARM] && !HOST_OPTION
            && st_r.in1_low_cnt == 2'(MIOE_MIN_PULSE_CYC - 1) && !st_r.in1_s[1]) begin
            st_nxt.int_pending = 1'b1; // R20
        end
        // serial register: counter or shift
        st_nxt.dec_seen = dec_bin;
        if (st_r.feature_enable[MIOE_EN_COUNT]) begin
            st_nxt.serial_count_reg = st_r.serial_count_reg - dec_delta; // R12 R23
        end else begin
            st_nxt.serial_count_reg = {st_r.serial_count_reg[2:0], st_r.si_tog_s[2]}; // R14
        end
        st_nxt.si_tog_s = {st_r.si_tog_s[1:0], SERIAL_IN};
        case (OP)
            MIOE_OP_ALU: begin
                case (ALU_FN)
                    MIOE_ALU_ADD: sum = add4(st_r.acc, mem_rd, 1'b0);
                    MIOE_ALU_ADDC: sum = add4(st_r.acc, mem_rd, st_r.carry);
                    MIOE_ALU_XOR: sum = {st_r.carry, st_r.acc ^ mem_rd};
                    default: sum = {st_r.carry, OPERAND[3:0]};
                endcase
                st_nxt.acc = sum[3:0]; // R04
                st_nxt.carry = sum[4]; // R04
            end
            MIOE_OP_LOAD_PTR: st_nxt.ptr = OPERAND[5:0]; // R01
            MIOE_OP_LOAD_DIRECT: st_nxt.acc = mem_rd; // R02
            MIOE_OP_EXCH_DIRECT: st_nxt.acc = mem_rd; // R02
            MIOE_OP_PTR_TO_DIGIT: st_nxt.digit = st_r.ptr[3:0]; // R03
            MIOE_OP_LOAD_ENABLE: st_nxt.feature_enable = OPERAND[3:0]; // R10
            MIOE_OP_SWAP_SERIAL: begin
                st_nxt.acc = st_r.serial_count_reg; // R11
                st_nxt.serial_count_reg = st_r.acc; // R11
                st_nxt.carry_hold = st_r.carry; // R13
                st_nxt.sync_on = st_r.carry; // R15
            end
            MIOE_OP_BYTE_FROM_MEM: st_nxt.byte_latch = {mem_rd, st_r.acc}; // R07
            MIOE_OP_BYTE_FROM_ROM: st_nxt.byte_latch = OPERAND; // R07
            MIOE_OP_PORT_TO_ACC: st_nxt.acc = st_r.port_rd[3:0]; // R09
            MIOE_OP_LOAD_GENERAL: st_nxt.gen = st_r.acc;
            default: ;
        endcase
        if (host_wr) begin
            st_nxt.byte_latch = st_r.port_rd; // R08
        end
        if (OP == MIOE_OP_RETURN) begin
            st_nxt.return_level1 = st_r.return_level2;
            st_nxt.return_level2 = st_r.return_level3;
        end else if (OP == MIOE_OP_CALL || int_take) begin
            st_nxt.return_level1 = PC_NEXT; // R19
            st_nxt.return_level2 = st_r.return_level1; // R19
            st_nxt.return_level3 = st_r.return_level2; // R19
        end
        if (int_take) begin
            st_nxt.feature_enable[MIOE_EN_ARM] = 1'b0; // R17
            st_nxt.int_pending = 1'b0;
            st_nxt.saved_skip = SKIP_IN; // R21
        end else if (OP == MIOE_OP_RETURN) begin
            st_nxt.saved_skip = 1'b0;
        end
        // a load-enable that re-arms in the same cycle wins over the auto-clear
        if (OP == MIOE_OP_LOAD_ENABLE && int_take) begin
            st_nxt.feature_enable = OPERAND[3:0]; // R10
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= '0;
            st_r.feature_enable <= MIOE_EN_RESET;
            st_r.sync_on <= 1'b1; // sync output after reset
            st_r.in1_s <= 3'h7;
            st_r.wr_s <= 3'h7;
            st_r.si_tog_s <= 3'h7;
        end else if (CE) begin
            st_r <= st_nxt; // R23
        end
    end

    // memory port: direct operand or pointer
    assign mem_bus.addr = mem_direct ? OPERAND[5:0] : st_r.ptr; // R01 R02
    assign mem_bus.we = (OP == MIOE_OP_EXCH_DIRECT) || (OP == MIOE_OP_PORT_TO_MEM);
    assign mem_bus.wdata = (OP == MIOE_OP_PORT_TO_MEM) ? st_r.port_rd[7:4] : st_r.acc; // R09

    mioe_digit_mem u_mem (
        .CLOCK(CLOCK),
        .CE(CE),
        .port(mem_bus.mem)
    );

    logic counter_mode;
    assign counter_mode = st_r.feature_enable[MIOE_EN_COUNT];
    always_comb begin
        if (counter_mode) begin
            SERIAL_OUT = st_r.feature_enable[MIOE_EN_SOUT]; // R13
            SYNC_CLOCK_OUT = st_r.carry_hold; // R13
        end else begin
            SERIAL_OUT = st_r.feature_enable[MIOE_EN_SOUT]
                         & st_r.serial_count_reg[3]; // R16
            // sync is high in the first half of each instruction cycle
            SYNC_CLOCK_OUT = st_r.sync_on & CLOCK; // R15
        end
    end

    assign PORT_O = st_r.byte_latch; // R07
    assign PORT_OE = (HOST_OPTION ? ~GEN_INPUTS[1] & ~GEN_INPUTS[2]
                      : st_r.feature_enable[MIOE_EN_DRIVE]) ? 8'hFF : 8'h00; // R18
    assign GPORT_O = st_r.gen;
    assign GPORT_OE = HOST_OPTION ? 4'h1 : 4'hF; // R06
    assign DIGIT_OUT = st_r.digit; // R03
    assign ACC = st_r.acc;
    assign CARRY = st_r.carry;
    assign FEATURE_ENABLE = st_r.feature_enable;
    assign INT_TAKE = int_take;
    assign PC_LOAD = int_take ? MIOE_INT_VECTOR : st_r.return_level1; // R19
    assign SKIP_OUT = (OP == MIOE_OP_RETURN) & st_r.saved_skip; // R21
    assign RETURN_STACK = {st_r.return_level3, st_r.return_level2, st_r.return_level1};

    a_int_clears_arm: assert property (@(posedge CLOCK) disable iff (RST) // R17
        (CE && int_take && OP != MIOE_OP_LOAD_ENABLE) |=> !FEATURE_ENABLE[MIOE_EN_ARM])
        else $error("arm bit not cleared after interrupt");
    a_int_vector_push: assert property (@(posedge CLOCK) disable iff (RST) // R19
        (CE && int_take) |-> ##0 PC_LOAD == MIOE_INT_VECTOR ##1 RETURN_STACK[9:0] == $past(PC_NEXT))
        else $error("interrupt push or vector wrong");
    a_int_needs_arm: assert property (@(posedge CLOCK) disable iff (RST) // R20
        int_take |-> FEATURE_ENABLE[MIOE_EN_ARM] && INS_DONE && !CHAIN_BUSY)
        else $error("interrupt taken without conditions");
    a_swap_exchange: assert property (@(posedge CLOCK) disable iff (RST) // R11
        (CE && OP == MIOE_OP_SWAP_SERIAL) |=> ACC == $past(st_r.serial_count_reg))
        else $error("serial swap lost data");
    a_enable_load: assert property (@(posedge CLOCK) disable iff (RST) // R10
        (CE && OP == MIOE_OP_LOAD_ENABLE) |=> FEATURE_ENABLE == $past(OPERAND[3:0]))
        else $error("feature enable not loaded");
    a_count_sout: assert property (@(posedge CLOCK) disable iff (RST) // R13
        counter_mode |-> SERIAL_OUT == FEATURE_ENABLE[MIOE_EN_SOUT])
        else $error("counter mode serial out wrong");
    a_shift_sout_off: assert property (@(posedge CLOCK) disable iff (RST) // R16
        (!counter_mode && !FEATURE_ENABLE[MIOE_EN_SOUT]) |-> !SERIAL_OUT)
        else $error("serial out not held low");
    a_digit_from_ptr: assert property (@(posedge CLOCK) disable iff (RST) // R03
        (CE && OP == MIOE_OP_PTR_TO_DIGIT) |=> DIGIT_OUT == $past(st_r.ptr[3:0]))
        else $error("digit output not loaded");
    a_port_drive: assert property (@(posedge CLOCK) disable iff (RST) // R18
        !HOST_OPTION |-> PORT_OE == {8{FEATURE_ENABLE[MIOE_EN_DRIVE]}})
        else $error("port drive mismatch");
endmodule
`default_nettype wire

// *** mioe_far_end.sv ***
// Purpose: far-side model: counter pulses, interrupt line, host bus strobes
// Assumes: serial and general input pins idle high; a released port shows the inverse of its last data
// Notes: serial pulses are paced by the link clock
`timescale 1ns/10ps
`default_nettype none
module mioe_far_end (
    input wire logic clock, // instruction clock
    input wire logic serial_clk, // link clock
    output logic serial_in, // serial pin
    output logic [3:0] gen_inputs, // general inputs
    output logic [7:0] port_val // far-side port level
);
    initial begin
        serial_in = 1'b1;
        gen_inputs = 4'hF;
        port_val = 8'h00;
    end
    task automatic serial_level(input logic v);
        @(posedge serial_clk) serial_in <= v;
    endtask
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge serial_clk) serial_in <= 1'b0;
            repeat (4) @(posedge serial_clk); // low far above two cycles
            serial_in <= 1'b1;
            repeat (4) @(posedge serial_clk);
        end
    endtask
    task automatic irq_pulse();
        @(posedge clock) gen_inputs[1] <= 1'b0;
        repeat (4) @(posedge clock);
        gen_inputs[1] <= 1'b1;
    endtask
    task automatic drive_port(input logic [7:0] d);
        @(posedge clock) port_val <= d;
    endtask
    task automatic host_write(input logic [7:0] d);
        @(posedge clock) gen_inputs[2] <= 1'b0;
        port_val <= d;
        @(posedge clock) gen_inputs[3] <= 1'b0;
        repeat (3) @(posedge clock);
        gen_inputs[3] <= 1'b1;
        repeat (5) @(posedge clock); // data held past the capture
        gen_inputs[2] <= 1'b1;
        port_val <= ~d;
    endtask
    task automatic host_read(input logic on);
        @(posedge clock) gen_inputs[2:1] <= on ? 2'b00 : 2'b11;
    endtask
endmodule
`default_nettype wire

// *** mioe_core_tb.sv ***
// Purpose: self-checking bench for the io, enable, serial and interrupt core
// Assumes: adder takes the memory digit at the pointer; xor and load keep carry
// Notes: memory digits are seeded from the port before the adder reads them
`timescale 1ns/10ps
`default_nettype none
module mioe_core_tb;
    import mioe_pkg::*;
    logic clock, serial_clk, rst, ins_done, chain_busy, skip_in, host_option, ce;
    mioe_op_type op;
    mioe_alu_type alu_fn, f;
    logic [7:0] operand, port_i, port_o, port_oe, port_val, d8;
    logic [9:0] pc_next, pc_load, next_pc;
    logic [3:0] gen_inputs, gport_i, gport_o, gport_oe, digit_out, acc, feature_enable, a, b, e;
    logic serial_in, serial_out, sync_clock_out, carry, int_take, skip_out, c, tk;
    logic [29:0] return_stack;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    integer seed = 32'h4fde;
    // wire level: device drive wins, else far side
    assign port_i = (port_oe & port_o) | (~port_oe & port_val);
    assign gport_i = (gport_oe & gport_o) | (~gport_oe & 4'hA);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        serial_clk = 1'b0;
        #7.3;
        forever #32 serial_clk = ~serial_clk;
    end
    mioe_far_end mioe_far_end_inst (.clock(clock), .serial_clk(serial_clk),
        .serial_in(serial_in), .gen_inputs(gen_inputs), .port_val(port_val));
    mioe_core mioe_core_inst (.CLOCK(clock), .RST(rst), .CE(ce), .SERIAL_CLK(serial_clk),
        .SERIAL_IN(serial_in), .OP(op), .ALU_FN(alu_fn), .OPERAND(operand), .PC_NEXT(pc_next),
        .INS_DONE(ins_done), .CHAIN_BUSY(chain_busy), .SKIP_IN(skip_in),
        .HOST_OPTION(host_option), .GEN_INPUTS(gen_inputs), .PORT_I(port_i), .PORT_O(port_o),
        .PORT_OE(port_oe), .GPORT_I(gport_i), .GPORT_O(gport_o), .GPORT_OE(gport_oe),
        .DIGIT_OUT(digit_out), .SERIAL_OUT(serial_out), .SYNC_CLOCK_OUT(sync_clock_out),
        .ACC(acc), .CARRY(carry), .FEATURE_ENABLE(feature_enable), .INT_TAKE(int_take),
        .PC_LOAD(pc_load), .SKIP_OUT(skip_out), .RETURN_STACK(return_stack));
    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic issue(input mioe_op_type o, input mioe_alu_type fn, input logic [7:0] d);
        @(posedge clock);
        op <= o;
        alu_fn <= fn;
        operand <= d;
        pc_next <= next_pc;
        @(posedge clock);
        op <= MIOE_OP_NONE;
        #1;
    endtask
    task automatic wait_cycles(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    // high phase then low phase of one cycle
    task automatic sync_chk(input logic hi, input logic lo);
        @(posedge clock);
        #5 chk(sync_clock_out, hi);
        #12.5 chk(sync_clock_out, lo);
    endtask
    task automatic do_reset(input logic h);
        @(posedge clock);
        rst <= 1'b1;
        host_option <= h;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        #1;
    endtask
    function automatic logic [4:0] alu_exp(mioe_alu_type fn, logic [3:0] x, logic [3:0] y,
        logic ci);
        case (fn)
            MIOE_ALU_ADD: return {1'b0, x} + {1'b0, y};
            MIOE_ALU_ADDC: return {1'b0, x} + {1'b0, y} + {4'h0, ci};
            MIOE_ALU_XOR: return {ci, x ^ y};
            default: return {ci, y};
        endcase
    endfunction
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        op = MIOE_OP_NONE;
        alu_fn = MIOE_ALU_ADD;
        operand = 8'h00;
        pc_next = 10'h000;
        next_pc = 10'h000;
        ins_done = 1'b1;
        chain_busy = 1'b0;
        skip_in = 1'b0;
        host_option = 1'b0;
        do_reset(1'b0);
        chk(feature_enable, MIOE_EN_RESET);
        chk({acc, carry, digit_out}, 9'h000);
        sync_chk(1'b1, 1'b0);
        chk(gport_oe, 4'hF);
        a = 4'h0;
        c = 1'b0;
        repeat (12) begin
            // drive bit kept off so the port reads the far side
            e = 4'($random(seed)) & 4'hB;
            f = mioe_alu_type'(2'($random(seed)));
            b = 4'($random(seed));
            mioe_far_end_inst.drive_port({b, 4'h0});
            issue(MIOE_OP_PORT_TO_MEM, MIOE_ALU_ADD, 8'h00);
            issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, {4'h0, e});
            chk(feature_enable, e);
            issue(MIOE_OP_ALU, f, {4'h0, b});
            {c, a} = alu_exp(f, a, b, c);
            chk({carry, acc, feature_enable}, {c, a, e});
        end
        @(posedge clock);
        ce <= 1'b0;
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h0F);
        chk(feature_enable, e);
        @(posedge clock);
        ce <= 1'b1;
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h04);
        issue(MIOE_OP_BYTE_FROM_ROM, MIOE_ALU_ADD, 8'hA5);
        chk({port_oe, port_o}, 16'hFFA5);
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h00);
        chk(port_oe, 8'h00);
        mioe_far_end_inst.drive_port(8'h3C);
        issue(MIOE_OP_PORT_TO_ACC, MIOE_ALU_ADD, 8'h00);
        chk(acc, 4'hC);
        mioe_far_end_inst.drive_port(8'hC3);
        issue(MIOE_OP_LOAD_PTR, MIOE_ALU_ADD, 8'h2B);
        issue(MIOE_OP_PTR_TO_DIGIT, MIOE_ALU_ADD, 8'h00);
        chk(digit_out, 4'hB);
        issue(MIOE_OP_LOAD_GENERAL, MIOE_ALU_ADD, 8'h06);
        chk(gport_o, 4'hC);
        issue(MIOE_OP_PORT_TO_MEM, MIOE_ALU_ADD, 8'h00);
        // counter mode: digit at pointer is C, preset F, three falling pulses
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h01);
        issue(MIOE_OP_ALU, MIOE_ALU_LOAD, 8'h03);
        issue(MIOE_OP_ALU, MIOE_ALU_ADD, 8'h01);
        issue(MIOE_OP_SWAP_SERIAL, MIOE_ALU_ADD, 8'h00);
        sync_chk(1'b0, 1'b0);
        chk(serial_out, 1'b0);
        mioe_far_end_inst.count_pulses(3);
        wait_cycles(20);
        issue(MIOE_OP_ALU, MIOE_ALU_LOAD, 8'h0F);
        issue(MIOE_OP_ALU, MIOE_ALU_ADD, 8'h01);
        issue(MIOE_OP_SWAP_SERIAL, MIOE_ALU_ADD, 8'h00);
        chk(acc, 4'hC);
        sync_chk(1'b1, 1'b1);
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h09);
        chk(serial_out, 1'b1);
        // shift mode with serial out on
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h08);
        mioe_far_end_inst.serial_level(1'b1);
        wait_cycles(8);
        chk(serial_out, 1'b1);
        issue(MIOE_OP_SWAP_SERIAL, MIOE_ALU_ADD, 8'h00);
        chk(acc, 4'hF);
        sync_chk(1'b1, 1'b0);
        mioe_far_end_inst.serial_level(1'b0);
        wait_cycles(8);
        chk(serial_out, 1'b0);
        mioe_far_end_inst.serial_level(1'b1);
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h00);
        wait_cycles(8);
        chk(serial_out, 1'b0);
        issue(MIOE_OP_ALU, MIOE_ALU_LOAD, 8'h03);
        issue(MIOE_OP_ALU, MIOE_ALU_ADD, 8'h00);
        issue(MIOE_OP_SWAP_SERIAL, MIOE_ALU_ADD, 8'h00);
        sync_chk(1'b0, 1'b0);
        // interrupt over a full stack, held off by a chain
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h02);
        for (int i = 0; i < 3; i++) begin
            next_pc = 10'h101 + 10'(i);
            issue(MIOE_OP_CALL, MIOE_ALU_ADD, 8'h00);
        end
        next_pc = 10'h155;
        @(posedge clock);
        pc_next <= next_pc;
        chain_busy <= 1'b1;
        ins_done <= 1'b0;
        skip_in <= 1'b1;
        mioe_far_end_inst.irq_pulse();
        tk = 1'b0;
        repeat (6) begin
            @(posedge clock);
            #1;
            if (int_take === 1'b1)
                tk = 1'b1;
        end
        chk(tk, 1'b0);
        @(posedge clock);
        chain_busy <= 1'b0;
        #1;
        chk(int_take, 1'b0);
        @(posedge clock);
        ins_done <= 1'b1;
        #1;
        for (n = 0; n < 20 && int_take !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 20) begin
            fail_count++;
            stop_test();
        end
        chk(pc_load, MIOE_INT_VECTOR);
        @(posedge clock);
        skip_in <= 1'b0;
        #1;
        chk(return_stack, {10'h101 + 10'h001, 10'h103, 10'h155});
        chk(feature_enable[MIOE_EN_ARM], 1'b0);
        issue(MIOE_OP_NONE, MIOE_ALU_ADD, 8'h00);
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h02);
        @(posedge clock);
        op <= MIOE_OP_RETURN;
        #1;
        chk({skip_out, pc_load}, {1'b1, 10'h155});
        @(posedge clock);
        op <= MIOE_OP_NONE;
        // host bus option
        do_reset(1'b1);
        chk(gport_oe, 4'h1);
        issue(MIOE_OP_LOAD_ENABLE, MIOE_ALU_ADD, 8'h04);
        chk(port_oe, 8'h00);
        d8 = 8'($random(seed));
        mioe_far_end_inst.host_write(d8);
        mioe_far_end_inst.host_read(1'b1);
        wait_cycles(2);
        chk({port_oe, port_o}, {8'hFF, d8});
        mioe_far_end_inst.host_read(1'b0);
        wait_cycles(2);
        stop_test();
    end
endmodule
`default_nettype wire
